// ==== hw/iho_pkg.sv ====
// Package of register map, field positions and state codes for the block
package iho_pkg;
   // Register select indices of the processor register port
   localparam logic [2:0] IHO_REG_IRQ = 3'h0;   // irq_status_reg / irq_mask_reg
   localparam logic [2:0] IHO_REG_CMD = 3'h1;   // cmd_status_reg
   localparam logic [2:0] IHO_REG_ADDR = 3'h2;  // addr_status_reg / addr_mode_reg
   localparam logic [2:0] IHO_REG_AUX = 3'h3;   // handshake_status_reg / aux_cmd_reg
   localparam logic [2:0] IHO_REG_DATA = 3'h7;  // Data in / data out
   // Interrupt status and mask bit positions
   localparam int IHO_IS_INT = 7;
   localparam int IHO_IS_BO = 6;
   localparam int IHO_IS_GET = 5;
   localparam int IHO_IS_APT = 3;
   localparam int IHO_IS_CMD = 2;
   localparam int IHO_IS_END = 1;
   localparam int IHO_IS_BI = 0;
   // Command status bit positions
   localparam int IHO_CS_UNDEF_UNIVERSAL_FLAG = 0;
   localparam int IHO_CS_DCAS = 1;
   localparam int IHO_CS_SPAS = 2;
   localparam int IHO_CS_RLC = 3;
   localparam int IHO_CS_LOK = 5;
   localparam int IHO_CS_REM = 6;
   localparam int IHO_CS_UNDEF_ADDRESSED_FLAG = 7;
   // Address mode bit positions
   localparam int IHO_AM_HLDA = 2;
   localparam int IHO_AM_HLDE = 3;
   localparam int IHO_AM_DSEL = 7;
   // Auxiliary command bit positions
   localparam int IHO_AX_DACD = 1;
   localparam int IHO_AX_DACR = 4;
   localparam int IHO_AX_FEOI = 5;
   localparam int IHO_AX_RFDR = 6;
   localparam int IHO_AX_RST = 7;
   // Handshake status bit positions
   localparam int IHO_HS_RFD = 4;
   localparam int IHO_HS_DAV = 5;
   localparam int IHO_HS_DAC = 6;
   // Reset values
   localparam logic [7:0] IHO_RST_BYTE = 8'h00;
   localparam logic [7:0] IHO_DIO_IDLE = 8'hff;
   // Acceptor handshake states
   typedef enum logic [1:0] {
      IHO_AC_RDY = 2'b00,
      IHO_AC_ACC = 2'b01,
      IHO_AC_DONE = 2'b10
   } iho_acc_t;
   // Source handshake states
   typedef enum logic [1:0] {
      IHO_TX_IDLE = 2'b00,
      IHO_TX_RFD = 2'b01,
      IHO_TX_DAC = 2'b10
   } iho_src_t;
endpackage : iho_pkg

// ==== hw/iho_holdoff_irq.sv ====
// Handshake holdoff, talker source and interrupt generation of the adapter
`timescale 1ns/1ps
`default_nettype none
module iho_holdoff_irq (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Processor register port, one access per pulse
   input wire logic cpu_access,
   input wire logic cpu_read,
   input wire logic [2:0] cpu_rs,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   output logic irq_n,
   // Interface state from the surrounding function logic
   input wire logic listen_active,
   input wire logic talk_active,
   input wire logic cmd_hold_req,
   input wire logic undef_universal_flag,
   input wire logic dev_clear_active,
   input wire logic serial_poll_active,
   input wire logic remote_local_change_flag,
   input wire logic lockout_active,
   input wire logic remote_active,
   input wire logic undef_addressed_flag,
   input wire logic trigger_active,
   input wire logic secondary_pass_flag,
   input wire logic [7:0] addr_status_in,
   // Bus management lines
   input wire logic atn_n_in,
   input wire logic eoi_n_in,
   output logic eoi_n_out,
   output logic eoi_oe_n,
   // Bus handshake lines
   input wire logic dav_n_in,
   output logic dav_n_out,
   output logic dav_oe_n,
   input wire logic nrfd_n_in,
   output logic nrfd_n_out,
   output logic nrfd_oe_n,
   input wire logic ndac_n_in,
   output logic ndac_n_out,
   output logic ndac_oe_n,
   // Bus data lines, active low
   input wire logic [7:0] dio_in,
   output logic [7:0] dio_out,
   output logic dio_oe_n
);
   import iho_pkg::*;

   typedef struct packed {
      logic [7:0] mask;
      logic [7:0] amode;
      logic [7:0] aux;
      logic [7:0] din;
      logic [7:0] dio;
      logic [7:0] isr;
      logic [7:0] csr;
      logic [7:0] rdata;
      iho_acc_t acc;
      iho_src_t src;
      logic dac_hold;
      logic rfd_hold;
      logic bi;
      logic endf;
      logic lvl;
      logic irq_n;
      logic eoi_oe_n;
      logic dav_oe_n;
      logic nrfd_oe_n;
      logic ndac_oe_n;
      logic dio_oe_n;
      logic low;
   } iho_state_t;

   iho_state_t st_r;
   iho_state_t st_nxt;
   logic wr;
   logic rd;
   logic dacr;
   logic rfdr;
   logic dsel;
   logic join_hs;
   logic [7:0] isr_live;
   logic cmd_sum;
   logic lvl_live;

   // Access decode and live status
   assign wr = cpu_access & ~cpu_read;
   assign rd = cpu_access & cpu_read;
   assign dacr = st_r.aux[IHO_AX_DACR];
   assign rfdr = st_r.aux[IHO_AX_RFDR];
   assign dsel = st_r.amode[IHO_AM_DSEL];
   assign join_hs = (~atn_n_in | listen_active) & ~st_r.aux[IHO_AX_RST];
   always_comb begin
      cmd_sum = serial_poll_active | remote_local_change_flag;
      if (!dsel) begin
         cmd_sum = cmd_sum | undef_universal_flag | dev_clear_active
                   | undef_addressed_flag;
      end
      // Own address reception and address status are never sources
      isr_live = IHO_RST_BYTE;
      isr_live[IHO_IS_BO] = talk_active & (st_r.src == IHO_TX_IDLE)
                            & ~st_r.aux[IHO_AX_RST];
      isr_live[IHO_IS_GET] = trigger_active & ~dsel;
      isr_live[IHO_IS_APT] = secondary_pass_flag;
      isr_live[IHO_IS_CMD] = cmd_sum;
      isr_live[IHO_IS_END] = st_r.endf;
      isr_live[IHO_IS_BI] = st_r.bi;
      isr_live[IHO_IS_INT] = |(isr_live[6:0] & st_r.mask[6:0]);
      lvl_live = isr_live[IHO_IS_INT] & st_r.mask[IHO_IS_INT];
   end

   // Next-state logic of the whole block
   always_comb begin
      st_nxt = st_r;
      st_nxt.low = 1'b0;
      // Live status registers, no latching
      st_nxt.isr = isr_live;
      st_nxt.csr = {undef_addressed_flag, remote_active, lockout_active,
                    1'b0, remote_local_change_flag, serial_poll_active,
                    dev_clear_active, undef_universal_flag};
      // Release bits last one cycle
      st_nxt.aux[IHO_AX_DACR] = 1'b0;
      st_nxt.aux[IHO_AX_RFDR] = 1'b0;
      // Register reads and their side effects
      if (rd) begin
         unique case (cpu_rs)
            IHO_REG_IRQ: st_nxt.rdata = st_r.isr;
            IHO_REG_CMD: st_nxt.rdata = st_r.csr;
            IHO_REG_ADDR: st_nxt.rdata = addr_status_in;
            IHO_REG_AUX: begin
               st_nxt.rdata = IHO_RST_BYTE;
               st_nxt.rdata[IHO_HS_DAC] = ndac_n_in;
               st_nxt.rdata[IHO_HS_DAV] = ~dav_n_in;
               st_nxt.rdata[IHO_HS_RFD] = nrfd_n_in;
            end
            IHO_REG_DATA: begin
               st_nxt.rdata = st_r.din;
               st_nxt.bi = 1'b0;
               st_nxt.endf = 1'b0;
            end
            default: st_nxt.rdata = IHO_RST_BYTE;
         endcase
      end
      // Register writes
      if (wr) begin
         unique case (cpu_rs)
            IHO_REG_IRQ: st_nxt.mask = cpu_wdata;
            IHO_REG_ADDR: st_nxt.amode = cpu_wdata;
            IHO_REG_AUX: st_nxt.aux = cpu_wdata;
            IHO_REG_DATA: begin
               if (st_r.src == IHO_TX_IDLE) begin
                  st_nxt.dio = ~cpu_wdata;
                  st_nxt.src = IHO_TX_RFD;
               end
            end
            default: st_nxt.rdata = st_r.rdata;
         endcase
      end
      // Interrupt request on rising masked level, cleared by status read
      st_nxt.lvl = lvl_live;
      if (rd && cpu_rs == IHO_REG_IRQ) begin
         st_nxt.irq_n = 1'b1;
      end
      if (lvl_live && !st_r.lvl) begin
         st_nxt.irq_n = 1'b0;
      end
      // Release bits drop pending holds
      if (dacr) begin
         st_nxt.dac_hold = 1'b0;
      end
      if (rfdr) begin
         st_nxt.rfd_hold = 1'b0;
      end
      // Acceptor handshake with holdoff
      if (!join_hs) begin
         st_nxt.acc = IHO_AC_RDY;
         st_nxt.nrfd_oe_n = 1'b1;
         st_nxt.ndac_oe_n = 1'b1;
         if (st_r.aux[IHO_AX_RST]) begin
            st_nxt.dac_hold = 1'b0;
            st_nxt.rfd_hold = 1'b0;
         end
      end else begin
         unique case (st_r.acc)
            IHO_AC_RDY: begin
               st_nxt.ndac_oe_n = 1'b0;
               st_nxt.nrfd_oe_n = ~st_nxt.rfd_hold;
               if (!dav_n_in && !st_r.nrfd_oe_n) begin
                  st_nxt.nrfd_oe_n = 1'b0;
               end else if (!dav_n_in) begin
                  st_nxt.acc = IHO_AC_ACC;
                  st_nxt.nrfd_oe_n = 1'b0;
                  if (!atn_n_in) begin
                     st_nxt.dac_hold = cmd_hold_req
                        | st_r.aux[IHO_AX_DACD];
                  end else begin
                     st_nxt.din = ~dio_in;
                     st_nxt.bi = 1'b1;
                     st_nxt.endf = ~eoi_n_in;
                     st_nxt.rfd_hold = st_r.amode[IHO_AM_HLDA]
                        | (st_r.amode[IHO_AM_HLDE] & ~eoi_n_in);
                  end
               end
            end
            IHO_AC_ACC: begin
               st_nxt.nrfd_oe_n = 1'b0;
               if (!st_r.dac_hold || dacr) begin
                  st_nxt.ndac_oe_n = 1'b1;
                  st_nxt.dac_hold = 1'b0;
                  st_nxt.acc = IHO_AC_DONE;
               end
            end
            IHO_AC_DONE: begin
               st_nxt.nrfd_oe_n = 1'b0;
               if (dav_n_in) begin
                  st_nxt.ndac_oe_n = 1'b0;
                  st_nxt.acc = IHO_AC_RDY;
               end
            end
            default: st_nxt.acc = IHO_AC_RDY;
         endcase
      end
      // Source handshake of the talker
      st_nxt.dio_oe_n = ~talk_active | st_r.aux[IHO_AX_RST];
      if (!talk_active || st_r.aux[IHO_AX_RST]) begin
         st_nxt.src = IHO_TX_IDLE;
         st_nxt.dav_oe_n = 1'b1;
         st_nxt.eoi_oe_n = 1'b1;
      end else begin
         unique case (st_r.src)
            IHO_TX_IDLE: st_nxt.dav_oe_n = 1'b1;
            IHO_TX_RFD: begin
               if (nrfd_n_in) begin
                  st_nxt.dav_oe_n = 1'b0;
                  st_nxt.eoi_oe_n = ~st_r.aux[IHO_AX_FEOI];
                  st_nxt.src = IHO_TX_DAC;
               end
            end
            IHO_TX_DAC: begin
               if (ndac_n_in) begin
                  st_nxt.dav_oe_n = 1'b1;
                  st_nxt.eoi_oe_n = 1'b1;
                  st_nxt.aux[IHO_AX_FEOI] = 1'b0;
                  st_nxt.src = IHO_TX_IDLE;
               end
            end
            default: st_nxt.src = IHO_TX_IDLE;
         endcase
      end
   end

   // State register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r <= '{mask: IHO_RST_BYTE, amode: IHO_RST_BYTE,
                   aux: IHO_RST_BYTE, din: IHO_RST_BYTE,
                   dio: IHO_DIO_IDLE, isr: IHO_RST_BYTE,
                   csr: IHO_RST_BYTE, rdata: IHO_RST_BYTE,
                   acc: IHO_AC_RDY, src: IHO_TX_IDLE,
                   dac_hold: 1'b0, rfd_hold: 1'b0, bi: 1'b0,
                   endf: 1'b0, lvl: 1'b0, irq_n: 1'b1,
                   eoi_oe_n: 1'b1, dav_oe_n: 1'b1, nrfd_oe_n: 1'b1,
                   ndac_oe_n: 1'b1, dio_oe_n: 1'b1, low: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign cpu_rdata = st_r.rdata;
   assign irq_n = st_r.irq_n;
   assign eoi_n_out = st_r.low;
   assign eoi_oe_n = st_r.eoi_oe_n;
   assign dav_n_out = st_r.low;
   assign dav_oe_n = st_r.dav_oe_n;
   assign nrfd_n_out = st_r.low;
   assign nrfd_oe_n = st_r.nrfd_oe_n;
   assign ndac_n_out = st_r.low;
   assign ndac_oe_n = st_r.ndac_oe_n;
   assign dio_out = st_r.dio;
   assign dio_oe_n = st_r.dio_oe_n;

   // Checks on the DAC and RFD release bits
   property p_dacr_clear;
      @(posedge sys_clk) disable iff (rst)
      st_r.aux[IHO_AX_DACR] |=> !st_r.aux[IHO_AX_DACR];
   endproperty
   a_dacr_clear: assert property (p_dacr_clear)
      else $error("DAC release bit did not clear");
   property p_rfdr_clear;
      @(posedge sys_clk) disable iff (rst)
      st_r.aux[IHO_AX_RFDR] |=> !st_r.aux[IHO_AX_RFDR];
   endproperty
   a_rfdr_clear: assert property (p_rfdr_clear)
      else $error("RFD release bit did not clear");
   // Checks on the holdoff behaviour
   property p_dac_held;
      @(posedge sys_clk) disable iff (rst)
      (st_r.acc == IHO_AC_ACC && st_r.dac_hold && !dacr && join_hs)
         |=> !st_r.ndac_oe_n;
   endproperty
   a_dac_held: assert property (p_dac_held)
      else $error("DAC released while held");
   property p_dacd_hold;
      @(posedge sys_clk) disable iff (rst)
      (join_hs && st_r.acc == IHO_AC_RDY && !dav_n_in && st_r.nrfd_oe_n
       && !atn_n_in && st_r.aux[IHO_AX_DACD]) |=> st_r.dac_hold;
   endproperty
   a_dacd_hold: assert property (p_dacd_hold)
      else $error("Command not held with disable bit set");
   property p_rfd_held;
      @(posedge sys_clk) disable iff (rst)
      (join_hs && st_r.acc == IHO_AC_RDY && st_r.rfd_hold && !rfdr)
         |=> !st_r.nrfd_oe_n;
   endproperty
   a_rfd_held: assert property (p_rfd_held)
      else $error("RFD released while held");
   // Checks on the talker source
   sequence s_dav_go;
      talk_active && !st_r.aux[IHO_AX_RST] && st_r.src == IHO_TX_RFD
         && nrfd_n_in;
   endsequence
   property p_eoi_last;
      @(posedge sys_clk) disable iff (rst)
      s_dav_go ##0 st_r.aux[IHO_AX_FEOI] |=> !st_r.eoi_oe_n && !st_r.dav_oe_n;
   endproperty
   a_eoi_last: assert property (p_eoi_last)
      else $error("EOI not driven with final byte");
   property p_dav_wait;
      @(posedge sys_clk) disable iff (rst)
      (st_r.src == IHO_TX_RFD && !nrfd_n_in) |=> st_r.dav_oe_n;
   endproperty
   a_dav_wait: assert property (p_dav_wait)
      else $error("DAV asserted before RFD");
   // Checks on the interrupt request and status bits
   sequence s_rise;
      lvl_live && !st_r.lvl;
   endsequence
   property p_irq_rise;
      @(posedge sys_clk) disable iff (rst)
      s_rise |=> !irq_n;
   endproperty
   a_irq_rise: assert property (p_irq_rise)
      else $error("No request on rising level");
   property p_irq_hold;
      @(posedge sys_clk) disable iff (rst)
      (!irq_n && !(rd && cpu_rs == IHO_REG_IRQ)) |=> !irq_n;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("Request dropped without status read");
   property p_irq_read;
      @(posedge sys_clk) disable iff (rst)
      (rd && cpu_rs == IHO_REG_IRQ && !(lvl_live && !st_r.lvl)) |=> irq_n;
   endproperty
   a_irq_read: assert property (p_irq_read)
      else $error("Request not cleared by status read");
   property p_no_edge;
      @(posedge sys_clk) disable iff (rst)
      (irq_n && st_r.lvl && lvl_live && !(rd && cpu_rs == IHO_REG_IRQ))
         |=> irq_n;
   endproperty
   a_no_edge: assert property (p_no_edge)
      else $error("Request raised without rising level");
   property p_cmd_sum;
      @(posedge sys_clk) disable iff (rst)
      1'b1 |=> st_r.isr[IHO_IS_CMD] == $past(cmd_sum);
   endproperty
   a_cmd_sum: assert property (p_cmd_sum)
      else $error("Command summary bit wrong");
   property p_dsel_get;
      @(posedge sys_clk) disable iff (rst)
      dsel |=> !st_r.isr[IHO_IS_GET];
   endproperty
   a_dsel_get: assert property (p_dsel_get)
      else $error("Trigger reported while deselected");
endmodule : iho_holdoff_irq
`default_nettype wire

// ==== test/iho_bus_model.sv ====
// Bus partner: controller or talker source and listener acceptor
`timescale 1ns/1ps
`default_nettype none
module iho_bus_model (
   // Clock
   input wire logic sys_clk,
   // Device drive enables and data
   input wire logic dav_oe_n,
   input wire logic nrfd_oe_n,
   input wire logic ndac_oe_n,
   input wire logic eoi_oe_n,
   input wire logic dio_oe_n,
   input wire logic [7:0] dio_out,
   // Acceptor control from the bench
   input wire logic lst_en,
   input wire logic lst_rdy,
   // Wired line levels seen by every party
   output logic atn_l,
   output logic eoi_l,
   output logic dav_l,
   output logic nrfd_l,
   output logic ndac_l,
   output logic [7:0] dio_l
);
   logic atn_m = 1'b1;
   logic eoi_m = 1'b1;
   logic dav_m = 1'b1;
   logic nrfd_m = 1'b1;
   logic ndac_m = 1'b1;
   logic [7:0] dio_m = 8'hff;
   logic [7:0] got_r = 8'h00;
   logic got_e = 1'b0;
   // Open-drain lines with pull-ups: low if any party pulls
   assign atn_l = atn_m;
   assign eoi_l = eoi_m & eoi_oe_n;
   assign dav_l = dav_m & dav_oe_n;
   assign nrfd_l = nrfd_m & nrfd_oe_n;
   assign ndac_l = ndac_m & ndac_oe_n;
   assign dio_l = dio_m & (dio_oe_n ? 8'hff : dio_out);
   // Acceptor, stalls on ready until the bench allows
   always @(posedge sys_clk) begin
      #1;
      if (!lst_en) begin
         nrfd_m = 1'b1;
         ndac_m = 1'b1;
      end else if (dav_l == 1'b0) begin
         nrfd_m = 1'b0;
         ndac_m = 1'b1;
         got_r = ~dio_l;
         got_e = ~eoi_l;
      end else begin
         nrfd_m = lst_rdy;
         ndac_m = 1'b0;
      end
   end
   // Source: wait for ready, place byte, then assert DAV
   task automatic src_put(input logic [7:0] b, input logic atn,
         input logic eoi, output logic ok);
      int n;
      n = 0;
      atn_m = atn;
      while (nrfd_l !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      dio_m = ~b;
      eoi_m = eoi;
      @(posedge sys_clk);
      #1;
      dav_m = 1'b0;
      ok = (n < 100);
   endtask : src_put
   // Source: wait for accept, drop DAV, release the lines
   task automatic src_end(output logic ok);
      int n;
      n = 0;
      while (ndac_l !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      dav_m = 1'b1;
      @(posedge sys_clk);
      #1;
      dio_m = 8'hff;
      eoi_m = 1'b1;
      atn_m = 1'b1;
      ok = (n < 100);
   endtask : src_end
endmodule : iho_bus_model
`default_nettype wire

// ==== test/iho_holdoff_irq_test.sv ====
// Testbench of the holdoff and interrupt block
`timescale 1ns/1ps
`default_nettype none
module iho_holdoff_irq_test;
   import iho_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic cpu_access = 1'b0;
   logic cpu_read = 1'b0;
   logic [2:0] cpu_rs = 3'h0;
   logic [7:0] cpu_wdata = 8'h00;
   logic [7:0] cpu_rdata, dio_l, dio_out, e;
   logic irq_n, ok, cb, gt, ap;
   logic listen_active = 1'b0;
   logic talk_active = 1'b0;
   logic cmd_hold_req = 1'b0;
   logic [8:0] cnd = 9'h000;
   logic [7:0] addr_status_in = 8'h00;
   logic lst_en = 1'b0;
   logic lst_rdy = 1'b0;
   logic atn_l, eoi_l, dav_l, nrfd_l, ndac_l;
   logic eoi_oe_n, dav_oe_n, nrfd_oe_n, ndac_oe_n, dio_oe_n;
   int fails = 0;
   int total_checks = 0;
   // Device under test
   iho_holdoff_irq uut (.sys_clk(sys_clk), .rst(rst),
      .cpu_access(cpu_access), .cpu_read(cpu_read), .cpu_rs(cpu_rs),
      .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .irq_n(irq_n),
      .listen_active(listen_active), .talk_active(talk_active),
      .cmd_hold_req(cmd_hold_req), .undef_universal_flag(cnd[0]),
      .dev_clear_active(cnd[1]), .serial_poll_active(cnd[2]),
      .remote_local_change_flag(cnd[3]), .trigger_active(cnd[4]),
      .lockout_active(cnd[5]), .remote_active(cnd[6]),
      .undef_addressed_flag(cnd[7]), .secondary_pass_flag(cnd[8]),
      .addr_status_in(addr_status_in), .atn_n_in(atn_l),
      .eoi_n_in(eoi_l), .eoi_n_out(), .eoi_oe_n(eoi_oe_n),
      .dav_n_in(dav_l), .dav_n_out(), .dav_oe_n(dav_oe_n),
      .nrfd_n_in(nrfd_l), .nrfd_n_out(), .nrfd_oe_n(nrfd_oe_n),
      .ndac_n_in(ndac_l), .ndac_n_out(), .ndac_oe_n(ndac_oe_n),
      .dio_in(dio_l), .dio_out(dio_out), .dio_oe_n(dio_oe_n));
   // Far side of the bus
   iho_bus_model m (.sys_clk(sys_clk), .dav_oe_n(dav_oe_n),
      .nrfd_oe_n(nrfd_oe_n), .ndac_oe_n(ndac_oe_n),
      .eoi_oe_n(eoi_oe_n), .dio_oe_n(dio_oe_n), .dio_out(dio_out),
      .lst_en(lst_en), .lst_rdy(lst_rdy), .atn_l(atn_l),
      .eoi_l(eoi_l), .dav_l(dav_l), .nrfd_l(nrfd_l),
      .ndac_l(ndac_l), .dio_l(dio_l));
   // 125 MHz clock
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   // Compare and count
   task automatic chk(input string nm, input logic [7:0] x,
         input logic [7:0] g);
      total_checks++;
      if (g !== x) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, x, g);
      end
   endtask : chk
   // Wait n edges, then step off the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc
   // One register write
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      cyc(1);
      cpu_access = 1'b1;
      cpu_read = 1'b0;
      cpu_rs = a;
      cpu_wdata = d;
      cyc(1);
      cpu_access = 1'b0;
   endtask : wr
   // One register read, compared with x
   task automatic rdc(input logic [2:0] a, input logic [7:0] x);
      cyc(1);
      cpu_access = 1'b1;
      cpu_read = 1'b1;
      cpu_rs = a;
      cyc(1);
      cpu_access = 1'b0;
      chk("cpu_rdata", x, cpu_rdata);
   endtask : rdc
   // Report and end the run
   task automatic give_verdict();
      $display("Checks %0d errors %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   // Watchdog against a hang
   initial begin
      #100000;
      fails++;
      $display("Error watchdog expected done seen timeout");
      give_verdict();
   end
   // Test sequence
   initial begin
      cyc(10);
      chk("irq_n", 8'h01, 8'(irq_n));
      chk("dio_out", 8'hff, dio_out);
      chk("oe_n", 8'h1f, {3'h0, eoi_oe_n, dav_oe_n, nrfd_oe_n,
         ndac_oe_n, dio_oe_n});
      rst = 1'b0;
      // Status table, with and without deselect
      wr(IHO_REG_IRQ, 8'h2c);
      for (int d = 0; d < 2; d++) begin
         wr(IHO_REG_ADDR, d ? 8'h80 : 8'h00);
         for (int i = 0; i < 9; i++) begin
            cnd = 9'h001 << i;
            cyc(3);
            e = (i == 4 || i == 8) ? 8'h00 : 8'h01 << i;
            rdc(IHO_REG_CMD, e);
            cb = (i == 2 || i == 3) || (d == 0 && (i < 2 || i == 7));
            gt = (i == 4) && (d == 0);
            ap = (i == 8);
            e = {cb | gt | ap, 1'b0, gt, 1'b0, ap, cb, 2'b00};
            rdc(IHO_REG_IRQ, e);
            chk("irq_n", 8'h01, 8'(irq_n));
         end
         cnd = 9'h000;
         cyc(3);
         rdc(IHO_REG_CMD, 8'h00);
      end
      // Request edge, ghost and mask re-arm
      wr(IHO_REG_ADDR, 8'h00);
      wr(IHO_REG_IRQ, 8'ha4);
      addr_status_in = 8'hff;
      cyc(4);
      chk("irq_n", 8'h01, 8'(irq_n));
      rdc(IHO_REG_ADDR, 8'hff);
      cnd = 9'h080;
      cyc(4);
      chk("irq_n", 8'h00, 8'(irq_n));
      cnd = 9'h000;
      cyc(4);
      chk("irq_n", 8'h00, 8'(irq_n));
      rdc(IHO_REG_IRQ, 8'h00);
      cyc(1);
      chk("irq_n", 8'h01, 8'(irq_n));
      cnd = 9'h080;
      cyc(4);
      rdc(IHO_REG_IRQ, 8'h84);
      cnd = 9'h090;
      cyc(4);
      chk("irq_n", 8'h01, 8'(irq_n));
      wr(IHO_REG_IRQ, 8'h00);
      wr(IHO_REG_IRQ, 8'ha4);
      cyc(4);
      chk("irq_n", 8'h00, 8'(irq_n));
      cnd = 9'h000;
      rdc(IHO_REG_IRQ, 8'h00);
      // Command holdoff: automatic, then all-command with 02
      wr(IHO_REG_IRQ, 8'hff);
      for (int k = 0; k < 5; k++) begin
         cmd_hold_req = (k < 2);
         if (k == 2) wr(IHO_REG_AUX, 8'h02);
         m.src_put(8'h20 + 8'(k), 1'b0, 1'b1, ok);
         chk("sent", 8'h01, 8'(ok));
         cyc(20);
         chk("ndac_oe_n", 8'(k == 4), 8'(ndac_oe_n));
         rdc(IHO_REG_AUX, k == 4 ? 8'h60 : 8'h20);
         chk("irq_n", 8'h01, 8'(irq_n));
         if (k < 4) wr(IHO_REG_AUX, k == 2 ? 8'h12 : 8'h10);
         m.src_end(ok);
         chk("accepted", 8'h01, 8'(ok));
      end
      cmd_hold_req = 1'b0;
      // Listener ready holdoff on all data and on end
      wr(IHO_REG_IRQ, 8'h00);
      listen_active = 1'b1;
      for (int k = 0; k < 3; k++) begin
         wr(IHO_REG_ADDR, k == 0 ? 8'h04 : 8'h08);
         m.src_put(8'ha5 ^ 8'(k), 1'b1, k != 2, ok);
         chk("sent", 8'h01, 8'(ok));
         m.src_end(ok);
         chk("accepted", 8'h01, 8'(ok));
         cyc(4);
         chk("nrfd_oe_n", 8'(k == 1), 8'(nrfd_oe_n));
         rdc(IHO_REG_IRQ, k == 2 ? 8'h03 : 8'h01);
         rdc(IHO_REG_DATA, 8'ha5 ^ 8'(k));
         if (k != 1) wr(IHO_REG_AUX, 8'h40);
         cyc(3);
         chk("nrfd_oe_n", 8'h01, 8'(nrfd_oe_n));
      end
      // Talker: byte shown at once, DAV only after ready
      listen_active = 1'b0;
      talk_active = 1'b1;
      lst_en = 1'b1;
      for (int k = 0; k < 2; k++) begin
         if (k == 1) wr(IHO_REG_AUX, 8'h20);
         wr(IHO_REG_DATA, 8'h3c + 8'(k));
         cyc(2);
         chk("dio_out", ~(8'h3c + 8'(k)), dio_out);
         chk("dio_oe_n", 8'h00, 8'(dio_oe_n));
         cyc(6);
         chk("dav_oe_n", 8'h01, 8'(dav_oe_n));
         lst_rdy = 1'b1;
         cyc(8);
         lst_rdy = 1'b0;
         chk("bus byte", 8'h3c + 8'(k), m.got_r);
         chk("bus end", 8'(k), 8'(m.got_e));
         chk("dav_oe_n", 8'h01, 8'(dav_oe_n));
      end
      // Idle talker shows byte-out, masked so no summary
      rdc(IHO_REG_IRQ, 8'h40);
      give_verdict();
   end
endmodule : iho_holdoff_irq_test
`default_nettype wire
